// ===== verilog/ppp_port.sv
// Parallel program port: pin sync, bus state decode, command decoder

// How it works
// - Two abort codes in consecutive write cycles during a program or erase cancel it and return to read mode.
// - Verify-select only chooses read-only or read/write operation, the latter adding the write state.
// - Bus state comes from the strobes, verify-select and program voltage; data driven in read, floated otherwise.
// - With chip-enable high the port is in standby and the data pins float.
// - A byte is accepted only with chip-enable low, output-enable high, write-enable low, verify high, voltage on.
// - Operations are chosen by the written command byte, not by pin states alone.
// - Array data appears on a read in read mode at the pin address; the verify modes show array data at the verify address, the other modes zero.
// - User and boot areas are both rewritable; a boot erase covers one boot block only.
// - No identification-code read; otherwise behaves as the standalone flash.
// - Address is taken at write-enable falling, command or data at write-enable rising.
// - Commands decode as read, program with address and data, program verify, erase twice, erase verify, abort twice.
// - Read mode after reset and after an abort, held until another command.
module ppp_port
  import ppp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // Programmer pins
  input  wire logic                      program_voltage_pin,
  input  wire logic                      verify_select_pin,
  input  wire logic                      ce_n_pin,
  input  wire logic                      oe_n_pin,
  input  wire logic                      we_n_pin,
  input  wire logic [3:0]                addr_low_nibble_pins,
  input  wire logic [3:0]                addr_second_nibble_pins,
  input  wire logic [7:0]                addr_upper_byte_pins,
  input  wire logic                      addr_bit17_pin,
  input  wire logic [ppp_pkg::DATA_W-1:0] data_port_pins_in,
  output logic      [ppp_pkg::DATA_W-1:0] data_port_pins_out,
  output logic                           data_port_pins_oe,
  // Flash array side
  output logic                           arr_valid,
  input  wire logic                      arr_ready,
  output logic      [1:0]                arr_op,
  output logic      [ppp_pkg::ADDR_W-1:0] arr_addr,
  output logic      [ppp_pkg::DATA_W-1:0] arr_wdata,
  output logic                           arr_boot_block,
  input  wire logic                      arr_busy,
  output logic                           arr_abort,
  output logic      [ppp_pkg::ADDR_W-1:0] arr_raddr,
  input  wire logic [ppp_pkg::DATA_W-1:0] arr_rdata
);
  // Two-stage synchronisers for every pin
  localparam int SW = 5 + ADDR_W + DATA_W;
  logic [SW-1:0] s1_r, s2_r;
  logic [SW-1:0] pins;
  assign pins = {program_voltage_pin, verify_select_pin, ce_n_pin, oe_n_pin, we_n_pin,
                 addr_bit17_pin, addr_upper_byte_pins, addr_second_nibble_pins,
                 addr_low_nibble_pins, data_port_pins_in};

  logic vpp, vrfy, ce_n, oe_n, we_n, we_n_d_r;
  logic [ADDR_W-1:0] a_s;
  logic [DATA_W-1:0] d_s;
  assign {vpp, vrfy, ce_n, oe_n, we_n, a_s, d_s} = s2_r;

  // Bus state decode
  logic st_read, st_write, we_fall, we_rise;
  assign st_read  = vpp && !ce_n && !oe_n && we_n;
  assign st_write = vpp && vrfy && !ce_n && oe_n;
  assign we_fall  = we_n_d_r && !we_n && st_write;
  assign we_rise  = !we_n_d_r && we_n && vpp && vrfy && !ce_n && oe_n;

  // Write capture and FIFO toward the array
  cmd_state_e        st_r, st_nxt;
  logic [ADDR_W-1:0] lat_a_r, lat_a_nxt, vfy_a_r, vfy_a_nxt;
  logic              abort1_r, abort1_nxt;
  logic              f_valid, f_ready;
  logic [WR_W-1:0]   f_data, q_data;
  logic              q_valid, q_ready;
  logic [1:0]        op_r, op_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              oe_r, oe_nxt;

  ppp_fifo #(.WIDTH(WR_W + 2), .DEPTH(DEPTH)) u_fifo (
    .clk      (clk),
    .nrst     (nrst),
    .in_valid (f_valid),
    .in_ready (f_ready),
    .in_data  ({op_nxt, f_data}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data ({arr_op, arr_addr, arr_wdata})
  );
  assign arr_valid = q_valid;
  assign q_ready   = arr_ready;
  assign f_data    = {lat_a_r, d_s};
  // Boot block erase is limited to one block of BOOT_BLOCK_BYTES; array uses this flag
  assign arr_boot_block = arr_addr < ADDR_W'(BOOT_BLOCK_BYTES);
  assign arr_raddr = (st_r == ST_READ) ? a_s : vfy_a_r;

  // Fresh command byte to next state; shared by idle and finished-busy paths
  function automatic cmd_state_e cmd_decode(input logic [DATA_W-1:0] c, input cmd_state_e cur);
    unique case (c)
      CMD_READ:      cmd_decode = ST_READ;
      CMD_PROGRAM:   cmd_decode = ST_PROG_WAIT;
      CMD_ERASE:     cmd_decode = ST_ERASE_WAIT;
      CMD_PROG_VFY:  cmd_decode = ST_PROG_VFY;
      CMD_ERASE_VFY: cmd_decode = ST_ERASE_VFY;
      default:       cmd_decode = cur;
    endcase
  endfunction : cmd_decode

  // Command decoder next state
  always_comb begin
    st_nxt     = st_r;
    lat_a_nxt  = we_fall ? a_s : lat_a_r;
    vfy_a_nxt  = vfy_a_r;
    abort1_nxt = abort1_r;
    op_nxt     = op_r;
    f_valid    = 1'b0;
    arr_abort  = 1'b0;
    if (we_rise) begin
      // Abort pair checked first; any other byte breaks the pair
      abort1_nxt = (d_s == CMD_ABORT) && !abort1_r;
      if (d_s == CMD_ABORT && abort1_r && (st_r == ST_BUSY || st_r == ST_ABORT_WAIT)) begin
        arr_abort = 1'b1;
        st_nxt    = ST_READ;
      end else begin
        unique case (st_r)
          ST_PROG_WAIT: begin
            op_nxt  = OP_PROGRAM;
            f_valid = 1'b1;
            st_nxt  = ST_BUSY;
          end
          ST_ERASE_WAIT: begin
            if (d_s == CMD_ERASE) begin
              op_nxt  = OP_ERASE;
              f_valid = 1'b1;
              st_nxt  = ST_BUSY;
            end else begin
              st_nxt = ST_READ;
            end
          end
          ST_BUSY, ST_ABORT_WAIT: begin
            // Waits for abort pair or a fresh command once idle
            // A command after the array finished is not lost
            if (d_s == CMD_ABORT) begin
              st_nxt = ST_ABORT_WAIT;
            end else if (arr_busy) begin
              st_nxt = st_r;
            end else begin
              st_nxt = cmd_decode(d_s, ST_READ);
            end
          end
          default: begin
            st_nxt = cmd_decode(d_s, st_r);
          end
        endcase
        // Verify commands read back at the address given with them
        if ((st_nxt == ST_PROG_VFY || st_nxt == ST_ERASE_VFY) && (d_s == CMD_PROG_VFY || d_s == CMD_ERASE_VFY)) begin
          vfy_a_nxt = lat_a_r;
        end
      end
    end
  end

  // Data pins: drive only in read state; no identification read exists
  always_comb begin
    oe_nxt   = st_read;
    dout_nxt = (st_r == ST_READ || st_r == ST_PROG_VFY || st_r == ST_ERASE_VFY) ? arr_rdata : '0;
  end
  assign data_port_pins_out = dout_r;
  assign data_port_pins_oe  = oe_r && st_read;

  // Registers only
  always_ff @(posedge clk) begin
    s1_r <= pins;
    s2_r <= s1_r;
    if (!nrst) begin
      st_r     <= ST_READ;
      we_n_d_r <= 1'b1;
      lat_a_r  <= '0;
      vfy_a_r  <= '0;
      abort1_r <= 1'b0;
      op_r     <= '0;
      dout_r   <= '0;
      oe_r     <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      we_n_d_r <= we_n;
      lat_a_r  <= lat_a_nxt;
      vfy_a_r  <= vfy_a_nxt;
      abort1_r <= abort1_nxt;
      op_r     <= op_nxt;
      dout_r   <= dout_nxt;
      oe_r     <= oe_nxt;
    end
  end
  logic unused_ready;
  assign unused_ready = f_ready;
endmodule : ppp_port

// ===== verilog/ppp_pkg.sv
// Package: constants for the parallel program port
package ppp_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_PROGRAM   = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY  = 8'hc0;
  localparam logic [7:0] CMD_ERASE     = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY = 8'ha0;
  localparam logic [7:0] CMD_ABORT     = 8'hff;
  // Widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // Write word width: address and data bits; the FIFO word adds the 2 op bits
  localparam int WR_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 8;
  // Boot area block, bytes
  localparam int BOOT_BLOCK_BYTES = 3584;
  // Command decoder states
  typedef enum logic [2:0] {
    ST_READ, ST_PROG_WAIT, ST_PROG_VFY, ST_ERASE_WAIT, ST_ERASE_VFY, ST_BUSY, ST_ABORT_WAIT
  } cmd_state_e;
  // Array operation kinds
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_ERASE   = 2'h2;
endpackage : ppp_pkg

// ===== verilog/ppp_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
module ppp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    rd_r, rd_nxt, wr_r, wr_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // Handshakes, honest full and empty
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r];

  // Wrap-around pointer step
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : step

  // Next pointer, count and storage
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = push ? step(wr_r) : wr_r;
    rd_nxt  = pop ? step(rd_r) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    if (push) begin
      mem_nxt[wr_r] = in_data;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
    mem_r <= mem_nxt;
  end
endmodule : ppp_fifo

// ===== test/flash_model.sv
// Flash array stand-in with busy time and stall
module flash_model (
  // Clock, reset and stall
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        stall,
  // Array side
  input  wire logic        arr_valid,
  output logic             arr_ready,
  input  wire logic [1:0]  arr_op,
  input  wire logic [16:0] arr_addr,
  input  wire logic [7:0]  arr_wdata,
  output logic             arr_busy,
  input  wire logic        arr_abort,
  input  wire logic [16:0] arr_raddr,
  output logic [7:0]       arr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  int         bsy = 0;
  // Low byte of address only, enough for the bench
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
  assign arr_ready = !stall && bsy == 0;
  assign arr_busy  = bsy != 0;
  assign arr_rdata = mem[arr_raddr[7:0]];
  // Busy long enough for an abort to land mid-operation
  always @(posedge clk) begin
    if (!nrst || arr_abort) bsy <= 0;
    else if (arr_valid && arr_ready) begin
      bsy <= 60;
      if (arr_op == 2'h1) mem[arr_addr[7:0]] <= arr_wdata;
    end else if (bsy != 0) bsy <= bsy - 1;
  end
endmodule : flash_model

// ===== test/ppp_port_assertions.sv
// Checker for the parallel program port
module ppp_port_chk
  import ppp_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Pins
  input wire logic        verify_select_pin,
  input wire logic        ce_n_pin,
  input wire logic        oe_n_pin,
  input wire logic        we_n_pin,
  input wire logic        data_port_pins_oe,
  // Array side
  input wire logic        arr_valid,
  input wire logic        arr_ready,
  input wire logic [1:0]  arr_op,
  input wire logic [16:0] arr_addr,
  input wire logic        arr_boot_block,
  input wire logic        arr_busy,
  input wire logic        arr_abort
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Five cycles cover the strobe synchronisers
  sequence s_rd; (!ce_n_pin && !oe_n_pin && we_n_pin)[*5]; endsequence
  sequence s_od; (!ce_n_pin && oe_n_pin && we_n_pin)[*5]; endsequence
  property p_rd; s_rd |-> data_port_pins_oe; endproperty
  property p_od; s_od |-> !data_port_pins_oe; endproperty
  property p_stby; ce_n_pin[*5] |-> !data_port_pins_oe; endproperty
  property p_ro; (verify_select_pin == 1'b0) [*8] |-> !$rose(arr_valid); endproperty
  property p_hold; arr_valid && !arr_ready |=> arr_valid && $stable({arr_op, arr_addr}); endproperty
  property p_boot; arr_valid |-> arr_boot_block == (arr_addr < BOOT_BLOCK_BYTES); endproperty
  property p_abort; arr_abort |-> arr_busy ##1 !arr_abort; endproperty
  property p_rst; @(posedge clk) disable iff (1'b0) !nrst |=> !arr_valid && !data_port_pins_oe; endproperty
  a_rd: assert property (p_rd) else $error("no drive in read state");
  a_od: assert property (p_od) else $error("drive in output disable");
  a_stby: assert property (p_stby) else $error("drive in standby");
  a_ro: assert property (p_ro) else $error("write taken in read-only");
  a_hold: assert property (p_hold) else $error("request changed while held");
  a_boot: assert property (p_boot) else $error("boot block flag wrong");
  a_abort: assert property (p_abort) else $error("bad abort pulse");
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : ppp_port_chk
bind ppp_port ppp_port_chk chk_u (.*);

// ===== test/ppp_port_tb.sv
// Testbench for the parallel program port
module ppp_port_tb;
  import ppp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, nrst = 0, stall = 0, program_voltage_pin = 1, verify_select_pin = 1;
  logic        ce_n_pin = 1, oe_n_pin = 1, we_n_pin = 1, addr_bit17_pin = 0;
  logic        data_port_pins_oe, arr_valid, arr_ready, arr_boot_block, arr_busy, arr_abort;
  logic [15:0] a16 = 0, a = 0, lfsr_r = 16'h001c;
  logic [7:0]  drv = 0, d = 0, data_port_pins_out, arr_wdata, arr_rdata;
  logic [1:0]  arr_op;
  logic [16:0] arr_addr, arr_raddr;
  logic [27:0] exp_q[$], e;
  int          error_cnt = 0, comparisons = 0, cycles = 0, abort_cnt = 0;
  // Address split over the pin groups, bit 16 absent
  wire [3:0] addr_low_nibble_pins = a16[3:0];
  wire [3:0] addr_second_nibble_pins = a16[7:4];
  wire [7:0] addr_upper_byte_pins = a16[15:8];
  wire [7:0] data_port_pins_in = data_port_pins_oe ? data_port_pins_out : drv;
  always #5 clk = ~clk;
  ppp_port dut_u (.*);
  flash_model model_u (.*);
  task automatic chk(input string n, input logic [26:0] x, input logic [26:0] g);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Strobes held well past the synchronisers
  task automatic wr(input logic [15:0] ad, input logic [7:0] v);
    a16 = ad;
    drv = v;
    ce_n_pin = 0;
    we_n_pin = 0;
    tick(5);
    we_n_pin = 1;
    tick(5);
    ce_n_pin = 1;
    tick(3);
  endtask : wr
  task automatic rd(input logic [15:0] ad, input logic [7:0] x);
    a16 = ad;
    ce_n_pin = 0;
    oe_n_pin = 0;
    tick(6);
    chk("read byte", x, data_port_pins_out);
    chk("read drive", 1, data_port_pins_oe);
    oe_n_pin = 1;
    ce_n_pin = 1;
    tick(5);
    chk("standby drive", 0, data_port_pins_oe);
  endtask : rd
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Oldest note meets each accepted request; erase compares op only
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
    if (nrst && arr_abort) abort_cnt++;
    if (nrst && arr_valid && arr_ready) begin
      e = exp_q.size() ? exp_q.pop_front() : 28'h0;
      chk("request", e[26:0], {arr_op, arr_addr, arr_wdata} & (e[27] ? '1 : 27'h6000000));
    end
  end
  initial begin
    tick(12);
    nrst = 1;
    tick(3);
    for (int i = 0; i < 3; i++) begin
      lfsr_r = lfsr(lfsr_r);
      a = i == 0 ? 16'h0100 : lfsr_r;
      d = lfsr_r[15:8];
      stall = i == 1;
      exp_q.push_back({1'b1, OP_PROGRAM, 1'b0, a, d});
      wr(16'h0, CMD_PROGRAM);
      wr(a, d);
      stall = 0;
      tick(70);
      wr(a, CMD_PROG_VFY);
      rd(a, d);
      wr(16'h0, CMD_READ);
      rd(a, d);
    end
    $display("program test done");
    exp_q.push_back({1'b0, OP_ERASE, 25'h0});
    wr(a, CMD_ERASE);
    wr(a, CMD_ERASE);
    wr(a, CMD_ABORT);
    wr(a, CMD_ABORT);
    tick(70);
    chk("abort pulses", 1, abort_cnt);
    rd(a, d);
    wr(a, CMD_ABORT);
    wr(a, CMD_ABORT);
    chk("idle abort pulses", 1, abort_cnt);
    wr(a, CMD_ERASE_VFY);
    rd(a, d);
    $display("erase test done");
    verify_select_pin = 0;
    wr(16'h0, CMD_PROGRAM);
    wr(a, ~d);
    tick(10);
    rd(a, d);
    verify_select_pin = 1;
    chk("pending notes", 0, exp_q.size());
    $display("read-only test done");
    end_of_test();
  end
endmodule : ppp_port_tb
